/* pkg/asr_defines.svh */
// Timing constants and geometry for the asynchronous SRAM host controller.
// Assumes a 20 MHz controller clock and the faster or slower speed grade.
`ifndef ASR_DEFINES_SVH
`define ASR_DEFINES_SVH

`define ASR_ADDR_W 20
`define ASR_DATA_W 16
`define ASR_CLK_PERIOD_NS 50
// Byte lane width, and the extra read cycle that the data-bus synchroniser costs.
`define ASR_LANE_W 8
`define ASR_DQ_SYNC_LAG 1
// Write pulse, select-to-write-end, access and cycle times, per grade, in ns.
`define ASR_WP_FAST_NS 35
`define ASR_WP_SLOW_NS 40
`define ASR_CW_FAST_NS 45
`define ASR_CW_SLOW_NS 50
`define ASR_RC_FAST_NS 45
`define ASR_RC_SLOW_NS 55
`define ASR_AA_FAST_NS 45
`define ASR_AA_SLOW_NS 55
`define ASR_OE_FAST_NS 30
`define ASR_OE_SLOW_NS 35
`define ASR_WC_FAST_NS 45
`define ASR_WC_SLOW_NS 55
// Operation recovery after retention, in ms.
`define ASR_RECOVERY_MS 5
`define ASR_NS_PER_MS 1000000
// Least times round up to whole cycles, never below one.
`define ASR_CYC_UP(ns) ((((ns) + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS) < 1 ? 1 : \
    (((ns) + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS))
`define ASR_RECOVERY_CYC ((`ASR_RECOVERY_MS * `ASR_NS_PER_MS) / `ASR_CLK_PERIOD_NS)
`define ASR_CNT_W 17

`endif

/* pkg/asr_pkg.sv */
// Types shared by the asynchronous SRAM host controller and its bench.
// Assumes asr_defines.svh is on the include path.
`include "asr_defines.svh"

package asr_pkg;

    typedef struct packed {
        logic write;
        logic [1:0] lane_n;
        logic [`ASR_ADDR_W-1:0] addr;
        logic [`ASR_DATA_W-1:0] wdata;
    } asr_req_t;

    typedef struct packed {
        logic [`ASR_ADDR_W-1:0] addr;
        logic select_low_active;
        logic select_high_active;
        logic write_n;
        logic output_en_n;
        logic low_lane_select_n;
        logic high_lane_select_n;
    } asr_pins_t;

    typedef enum logic [2:0] {
        ST_RECOVER,
        ST_IDLE,
        ST_READ,
        ST_WRITE,
        ST_GAP,
        ST_RETAIN
    } asr_state_t;

endpackage

/* rtl/asr_host.sv */
// Host-side controller for a clockless 1M x 16 asynchronous SRAM.
// Assumes the SRAM pins connect directly and the data bus is resolved outside.
// Assumes requests come from logic on this clock; retain_i may change at any time.
//
// Contract
// - Controller holds the write window at least 35 or 40 ns.
// - Controller keeps the chip selected 45 or 50 ns until write end.
// - Address may change right after a write ends.
// - Consecutive reads spaced at least 45 or 55 ns.
// - Read data valid at most 45 or 55 ns after address; no earlier sample.
// - Data valid 30 or 35 ns after output enable falls; wait before sampling.
// - Consecutive writes spaced at least 45 or 55 ns.
// - Retention via active-high select low; other inputs may float.
// - After supply returns, stay deselected 5 ms before any access.
`include "asr_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module asr_host #(
    parameter bit SLOW_GRADE = 1'b0,
    parameter int RECOVERY_CYC = `ASR_RECOVERY_CYC
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic req_valid_i,
    input wire asr_pkg::asr_req_t req_i,
    output logic req_ready_o,
    output logic rd_valid_o,
    output logic [`ASR_DATA_W-1:0] rd_data_o,
    input wire logic retain_i,
    output logic busy_o,
    output asr_pkg::asr_pins_t pins_o,
    input wire logic [`ASR_DATA_W-1:0] dq_i,
    output logic [`ASR_DATA_W-1:0] dq_o,
    output logic [`ASR_DATA_W-1:0] dq_oe_o
);

    // cycle counts; the strictest figure sets each phase.
    localparam int WP_NS = SLOW_GRADE ? `ASR_WP_SLOW_NS : `ASR_WP_FAST_NS;
    localparam int CW_NS = SLOW_GRADE ? `ASR_CW_SLOW_NS : `ASR_CW_FAST_NS;
    localparam int AA_NS = SLOW_GRADE ? `ASR_AA_SLOW_NS : `ASR_AA_FAST_NS;
    localparam int OE_NS = SLOW_GRADE ? `ASR_OE_SLOW_NS : `ASR_OE_FAST_NS;
    localparam int RC_NS = SLOW_GRADE ? `ASR_RC_SLOW_NS : `ASR_RC_FAST_NS;
    localparam int WC_NS = SLOW_GRADE ? `ASR_WC_SLOW_NS : `ASR_WC_FAST_NS;
    localparam int WR_NS = (CW_NS > WP_NS) ? CW_NS : WP_NS;
    localparam int RD_NS0 = (AA_NS > OE_NS) ? AA_NS : OE_NS;
    localparam int RD_NS = (RD_NS0 > RC_NS) ? RD_NS0 : RC_NS;
    localparam int WR_CYC = `ASR_CYC_UP(WR_NS > WC_NS ? WR_NS : WC_NS);
    localparam int RD_CYC = `ASR_CYC_UP(RD_NS);
    // The data bus reaches the capture flop two cycles late, so a read stays open
    // one cycle beyond its access time; otherwise the idle bus from before the
    // read would be captured instead of the word.
    localparam int RD_HOLD = RD_CYC + `ASR_DQ_SYNC_LAG;
    localparam int CW = `ASR_CNT_W;

    // Phase counters run down to zero, so a phase of n cycles loads n minus one.
    function automatic logic [CW-1:0] to_cnt(input int n);
        to_cnt = CW'(n - 1);
    endfunction

    // Expands the two active-low lane selects into a per-bit lane mask.
    function automatic logic [`ASR_DATA_W-1:0] lane_to_mask(input logic [1:0] lane_n);
        lane_to_mask = {{`ASR_LANE_W{!lane_n[1]}}, {`ASR_LANE_W{!lane_n[0]}}};
    endfunction

    asr_pkg::asr_state_t state_q, state_d;
    logic [CW-1:0] cnt_q, cnt_d;
    asr_pkg::asr_req_t req_q;
    logic [`ASR_DATA_W-1:0] dq_s1_q, dq_s2_q, rd_data_q;
    logic ret_s1_q, ret_s2_q, rd_valid_q;
    asr_pkg::asr_pins_t pins_q;
    logic [`ASR_DATA_W-1:0] dq_oe_q;

    wire cnt_done = (cnt_q == '0);
    // Retention is honoured only between accesses, so a running access always ends.
    wire take = (state_q == asr_pkg::ST_IDLE) && req_valid_i && !ret_s2_q;
    wire [`ASR_DATA_W-1:0] lane_mask = lane_to_mask(req_q.lane_n);
    wire rd_done = (state_q == asr_pkg::ST_GAP) && !req_q.write;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_done ? cnt_q : cnt_q - CW'(1);
        case (state_q)
            asr_pkg::ST_RECOVER: begin
                if (ret_s2_q) begin
                    state_d = asr_pkg::ST_RETAIN;
                end else if (cnt_done) begin
                    state_d = asr_pkg::ST_IDLE;
                end
            end
            asr_pkg::ST_IDLE: begin
                if (ret_s2_q) begin
                    state_d = asr_pkg::ST_RETAIN;
                end else if (take) begin
                    state_d = req_i.write ? asr_pkg::ST_WRITE : asr_pkg::ST_READ;
                    cnt_d = req_i.write ? to_cnt(WR_CYC) : to_cnt(RD_HOLD);
                end
            end
            asr_pkg::ST_READ: begin
                // held until the synchronised sample is valid.
                if (cnt_done) begin
                    state_d = asr_pkg::ST_GAP;
                end
            end
            asr_pkg::ST_WRITE: begin
                if (cnt_done) begin
                    state_d = asr_pkg::ST_GAP;
                end
            end
            asr_pkg::ST_GAP: begin
                // one released cycle spaces accesses and lets the bus turn round.
                state_d = asr_pkg::ST_IDLE;
            end
            asr_pkg::ST_RETAIN: begin
                // Leaving retention always passes through the full recovery wait.
                if (!ret_s2_q) begin
                    state_d = asr_pkg::ST_RECOVER;
                    cnt_d = to_cnt(RECOVERY_CYC);
                end
            end
            default: begin
                state_d = asr_pkg::ST_RECOVER;
            end
        endcase
    end

    // Pin image for the next state; every pin leaves a flip-flop to avoid glitches.
    asr_pkg::asr_pins_t pins_d;
    logic [`ASR_DATA_W-1:0] dq_oe_d;
    wire active_d = (state_d == asr_pkg::ST_READ) || (state_d == asr_pkg::ST_WRITE);
    wire [1:0] lane_d = take ? req_i.lane_n : req_q.lane_n;
    always_comb begin
        pins_d = pins_q;
        pins_d.select_low_active = !active_d;
        pins_d.select_high_active = active_d;
        pins_d.low_lane_select_n = active_d ? lane_d[0] : 1'b1;
        pins_d.high_lane_select_n = active_d ? lane_d[1] : 1'b1;
        // read asserts output enable; write held full span
        pins_d.output_en_n = (state_d != asr_pkg::ST_READ);
        pins_d.write_n = (state_d != asr_pkg::ST_WRITE);
        // address only changes when a new access is taken
        if (take) begin
            pins_d.addr = req_i.addr;
        end
        // A write with both lanes high strobes a memory in standby and stores nothing.
        // drive only selected lanes while writing
        dq_oe_d = '0;
        if (state_d == asr_pkg::ST_WRITE) begin
            dq_oe_d = lane_to_mask(lane_d);
        end
    end

    // Reset leaves both selects inactive, so the memory sits in standby at once.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_q <= asr_pkg::ST_RECOVER;
            cnt_q <= to_cnt(RECOVERY_CYC);
            req_q <= '0;
            pins_q <= '{addr: '0, select_low_active: 1'b1, select_high_active: 1'b0,
                        write_n: 1'b1, output_en_n: 1'b1,
                        low_lane_select_n: 1'b1, high_lane_select_n: 1'b1};
            dq_oe_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            pins_q <= pins_d;
            dq_oe_q <= dq_oe_d;
            if (take) begin
                req_q <= req_i;
            end
        end
    end

    // Data pins and the retention request come from outside and are synchronised.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            dq_s1_q <= '0;
            dq_s2_q <= '0;
            ret_s1_q <= 1'b0;
            ret_s2_q <= 1'b0;
            rd_data_q <= '0;
            rd_valid_q <= 1'b0;
        end else begin
            dq_s1_q <= dq_i;
            dq_s2_q <= dq_s1_q;
            ret_s1_q <= retain_i;
            ret_s2_q <= ret_s1_q;
            // sample at read end after synchroniser delay
            rd_valid_q <= rd_done;
            if (rd_done) begin
                rd_data_q <= dq_s2_q & lane_mask;
            end
        end
    end

    // Ready comes from the state and retention synchroniser flops alone, so it never depends on req_valid_i.
    assign req_ready_o = (state_q == asr_pkg::ST_IDLE) && !ret_s2_q;
    assign rd_valid_o = rd_valid_q;
    assign rd_data_o = rd_data_q;
    assign busy_o = (state_q != asr_pkg::ST_IDLE);
    assign pins_o = pins_q;
    // Write data comes from the request register, steady across the whole window.
    assign dq_o = req_q.wdata;
    assign dq_oe_o = dq_oe_q;

endmodule

`default_nettype wire

/* sim/asr_sram_model.sv */
// Behavioural 1M x 16 asynchronous SRAM that faces the host controller.
// Assumes the host drives its pins from flops; returns the resolved bus.
`include "asr_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module asr_sram_model (
    input wire logic clk_i,
    input wire asr_pkg::asr_pins_t pins_i,
    input wire logic [15:0] host_dq_i,
    input wire logic [15:0] host_oe_i,
    output logic [15:0] bus_o
);
    logic [15:0] mem [int];
    logic [15:0] junk_q = 16'hA5C3;
    logic [15:0] lane_m;
    logic [15:0] rd_m;
    logic [15:0] word;
    logic sel;
    assign sel = !pins_i.select_low_active && pins_i.select_high_active;
    assign lane_m = {{8{!pins_i.high_lane_select_n}}, {8{!pins_i.low_lane_select_n}}};
    assign rd_m = (sel && pins_i.write_n && !pins_i.output_en_n) ? lane_m : 16'h0000;
    // A floating line shows a changing pattern so a stale sample cannot pass.
    always @(posedge clk_i) junk_q <= ~junk_q;
    always @(pins_i or host_dq_i or host_oe_i or junk_q) begin
        word = mem.exists(pins_i.addr) ? mem[pins_i.addr] : ~junk_q;
        if (sel && !pins_i.write_n && lane_m != 16'h0000) begin
            mem[pins_i.addr] = (word & ~lane_m) | (host_dq_i & lane_m);
        end
        bus_o = (host_oe_i & host_dq_i) | (~host_oe_i & rd_m & word)
            | (~host_oe_i & ~rd_m & junk_q);
    end
endmodule
`default_nettype wire

/* sim/asr_host_sva.sv */
// Checker for the host controller's SRAM pins and request handshake.
// Assumes the fast grade and a single clock domain.
`include "asr_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module asr_host_sva (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic req_valid_i,
    input wire asr_pkg::asr_req_t req_i,
    input wire logic req_ready_o,
    input wire logic rd_valid_o,
    input wire logic busy_o,
    input wire logic retain_i,
    input wire asr_pkg::asr_pins_t pins_o,
    input wire logic [`ASR_DATA_W-1:0] dq_oe_o
);
    logic [15:0] lane_m;
    logic sel;
    assign lane_m = {{8{!pins_o.high_lane_select_n}}, {8{!pins_o.low_lane_select_n}}};
    assign sel = !pins_o.select_low_active && pins_o.select_high_active;
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    stray_drive_a: assert property (dq_oe_o != 16'h0000 |-> !pins_o.write_n)
        else $error("Data bus driven outside a write.");
    write_qual_a: assert property (!pins_o.write_n |-> sel && lane_m != 16'h0000)
        else $error("Write strobe without full select.");
    write_seq_a: assert property (req_valid_i && req_ready_o && req_i.write |=>
        !pins_o.write_n && dq_oe_o == lane_m && lane_m[8] != $past(req_i.lane_n[1])
        ##1 pins_o.write_n && dq_oe_o == 16'h0000) else $error("Write window wrong.");
    read_seq_a: assert property (req_valid_i && req_ready_o && !req_i.write |=>
        !pins_o.output_en_n && pins_o.write_n && pins_o.addr == $past(req_i.addr)
        ##1 !pins_o.output_en_n ##1 pins_o.output_en_n ##1 rd_valid_o)
        else $error("Read sequence wrong.");
    read_float_a: assert property (!pins_o.output_en_n |-> dq_oe_o == 16'h0000)
        else $error("Bus driven during a read.");
    take_space_a: assert property (req_valid_i && req_ready_o |=> !req_ready_o [*2])
        else $error("Requests too close.");
    retain_desel_a: assert property (retain_i [*8] |->
        !pins_o.select_high_active && !req_ready_o) else $error("Retention does not deselect.");
    idle_quiet_a: assert property (req_ready_o |->
        !busy_o && pins_o.write_n && dq_oe_o == 16'h0000) else $error("Idle state not quiet.");
    addr_hold_a: assert property (!(req_valid_i && req_ready_o) |=> $stable(pins_o.addr))
        else $error("Address moved without a new access.");
endmodule
bind asr_host asr_host_sva i_asr_host_sva (.*);
`default_nettype wire

/* sim/asr_host_tb_top.sv */
// Self-checking bench for the SRAM host controller with a behavioural SRAM.
// Assumes the checker is bound and recovery is shortened to ten cycles.
`include "asr_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module asr_host_tb_top;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic req_valid_i = 1'b0;
    logic retain_i = 1'b0;
    asr_pkg::asr_req_t req_i = '0;
    asr_pkg::asr_pins_t pins_o;
    logic req_ready_o, rd_valid_o, busy_o;
    logic [15:0] rd_data_o, dq_i, dq_o, dq_oe_o;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cyc = 0;
    asr_host #(.SLOW_GRADE(1'b0), .RECOVERY_CYC(10)) i_asr_host (.*);
    asr_sram_model i_asr_sram_model (.clk_i(clk_i), .pins_i(pins_o), .host_dq_i(dq_o),
        .host_oe_i(dq_oe_o), .bus_o(dq_i));
    initial forever #25 clk_i = ~clk_i;
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_mismatch++;
            complete_run();
        end
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic op(input logic wr, input logic [1:0] ln, input logic [19:0] a,
        input logic [15:0] d, input logic [15:0] exp);
        @(posedge clk_i);
        req_valid_i <= 1'b1;
        req_i <= '{write: wr, lane_n: ln, addr: a, wdata: d};
        do @(posedge clk_i); while (req_ready_o !== 1'b1);
        req_valid_i <= 1'b0;
        @(posedge clk_i);
        chk("busy after take", {15'h0000, busy_o}, 16'h0001);
        if (!wr) begin
            do @(posedge clk_i); while (rd_valid_o !== 1'b1);
            chk("read data", rd_data_o, exp);
        end
    endtask
    task automatic t_word();
        op(1'b1, 2'b00, 20'hFFFFF, 16'hBEEF, 16'h0000);
        op(1'b1, 2'b00, 20'h00000, 16'h1234, 16'h0000);
        op(1'b0, 2'b00, 20'hFFFFF, 16'h0000, 16'hBEEF);
        op(1'b0, 2'b00, 20'h00000, 16'h0000, 16'h1234);
        $display("word test done");
    endtask
    task automatic t_lanes();
        op(1'b1, 2'b10, 20'hFFFFF, 16'h55AA, 16'h0000);
        op(1'b1, 2'b01, 20'hFFFFF, 16'hC35A, 16'h0000);
        op(1'b0, 2'b00, 20'hFFFFF, 16'h0000, 16'hC3AA);
        op(1'b0, 2'b10, 20'hFFFFF, 16'h0000, 16'h00AA);
        op(1'b0, 2'b01, 20'hFFFFF, 16'h0000, 16'hC300);
        $display("lane test done");
    endtask
    task automatic t_retain();
        int n;
        n = 0;
        @(posedge clk_i);
        retain_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk("ready in retention", {15'h0000, req_ready_o}, 16'h0000);
        chk("high select", {15'h0000, pins_o.select_high_active}, 16'h0000);
        retain_i <= 1'b0;
        do begin
            @(posedge clk_i);
            n++;
        end while (req_ready_o !== 1'b1);
        chk("recovery wait", {15'h0000, n >= 10}, 16'h0001);
        op(1'b0, 2'b00, 20'h00000, 16'h0000, 16'h1234);
        $display("retention test done");
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        srst_i <= 1'b0;
        t_word();
        t_lanes();
        t_retain();
        complete_run();
    end
endmodule
`default_nettype wire
